// ===== common/cpc_pkg.sv
// Purpose: Shared constants and types for the coprocessor condition
//          sequencer.
// Assumes: APB register bus, 32-bit data; 16-bit coprocessor bus words.
// Notes:   Register map and response word layout are local choices.
// How it works
// - Branch sends whole opcode word to condition port
// - Then read response port; coprocessor may request services
// - Branch false: next insn; true: pointer plus displacement
// - Scan pointer sits on first displacement word
// - 16 or 32 bit displacement, short one sign-extended
// - Set opcode: id 11-9, 001 in 8-6, EA 5-0
// - Set/decrement/trap send the word after opcode
// - Set ends with zero to five EA words
// - Set writes byte zeros on false, ones on true
// - Decrement opcode: 001001 in 8-3, counter in 2-0
// - Decrement displacement 16 bits, sign-extended
// - True ends; false decrements low word, -1 falls through
// - Decrement target is pointer plus displacement
// - Trap opcode: 001111 in 8-3, opmode in 2-0
// - Opmode 010 one, 011 two, 100 none; 000/001 decode as set; else invalid
// - Trap operand words skipped, left for handler
// - Trap true starts exception; false continues
// - Non-null primitive without come-again is protocol violation
// - Branch opcode: selector 5-0, form in 8-6
package cpc_pkg;
    // ============================================================
    // Register map
    localparam int CPC_AW = 8;
    localparam logic [7:0] CPC_A_CTRL = 8'h00;
    localparam logic [7:0] CPC_A_OPW = 8'h04;
    localparam logic [7:0] CPC_A_SELW = 8'h08;
    localparam logic [7:0] CPC_A_EXT = 8'h0c;
    localparam logic [7:0] CPC_A_SCAN = 8'h10;
    localparam logic [7:0] CPC_A_DISP = 8'h14;
    localparam logic [7:0] CPC_A_CNT = 8'h18;
    localparam logic [7:0] CPC_A_STAT = 8'h1c;
    localparam logic [7:0] CPC_A_NPC = 8'h20;
    localparam logic [7:0] CPC_A_BYTE = 8'h24;
    localparam logic [7:0] CPC_A_SVC = 8'h28;
    localparam int CPC_START_BIT = 0;
    localparam int CPC_EA_LSB = 4;
    localparam logic [2:0] CPC_EA_MAX = 3'h5;
    // ============================================================
    // Opcode fields
    localparam logic [3:0] CPC_FLINE = 4'hf;
    localparam logic [2:0] CPC_CLS_BR_W = 3'h2;
    localparam logic [2:0] CPC_CLS_BR_L = 3'h3;
    localparam logic [2:0] CPC_CLS_COND = 3'h1;
    localparam logic [2:0] CPC_MODE_DBR = 3'h1;
    localparam logic [2:0] CPC_MODE_TRAP = 3'h7;
    localparam logic [2:0] CPC_TRAP_OP1 = 3'h2;
    localparam logic [2:0] CPC_TRAP_OP2 = 3'h3;
    localparam logic [2:0] CPC_TRAP_OP0 = 3'h4;
    localparam logic [2:0] CPC_EA_ABS_W = 3'h0;
    localparam logic [2:0] CPC_EA_ABS_L = 3'h1;
    // ============================================================
    // Coprocessor port and response word
    localparam logic CPC_CIR_COND = 1'b0;
    localparam logic CPC_CIR_RESP = 1'b1;
    localparam int CPC_RSP_CA = 15;
    localparam int CPC_RSP_COND = 0;
    localparam logic [5:0] CPC_RSP_NULL = 6'h00;
    localparam logic [7:0] CPC_BYTE_TRUE = 8'hff;
    localparam logic [7:0] CPC_BYTE_FALSE = 8'h00;
    localparam logic [15:0] CPC_CNT_END = 16'hffff;

    typedef enum logic [2:0] {
        CPC_K_BR = 3'b000,
        CPC_K_SET = 3'b001,
        CPC_K_DBR = 3'b010,
        CPC_K_TRAP = 3'b011,
        CPC_K_BAD = 3'b100
    } cpc_kind_t;

    typedef struct packed {
        cpc_kind_t kind;
        logic long_disp;
        logic [2:0] dreg;
        logic [1:0] opwords;
    } cpc_dec_t;

    typedef enum logic [2:0] {
        CPC_S_IDLE = 3'b000,
        CPC_S_WRC = 3'b001,
        CPC_S_WREL = 3'b010,
        CPC_S_RDR = 3'b011,
        CPC_S_RREL = 3'b100,
        CPC_S_DONE = 3'b101
    } cpc_state_t;
endpackage

// ===== hw/cpc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Bus inputs are stable while the strobe they ride with is high.
// Notes:   First stage is read by the second stage only.
`timescale 1ns/100ps
module cpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // cpc_sync

// ===== hw/cpc_decode.sv
// Purpose: Classifies a conditional-category opcode word.
// Assumes: Word is the first word of the instruction.
// Notes:   Pure combinational decode.
`timescale 1ns/100ps
module cpc_decode
    import cpc_pkg::*;
(
    // Opcode in
    input wire logic [15:0] op_word,
    // Decoded out
    output cpc_dec_t dec
);
    always_comb
    begin
        dec.kind = CPC_K_BAD;
        dec.long_disp = 1'b0;
        dec.dreg = op_word[2:0];
        dec.opwords = 2'h0;
        if (op_word[15:12] == CPC_FLINE)
        begin
            case (op_word[8:6])
                CPC_CLS_BR_W: dec.kind = CPC_K_BR;
                CPC_CLS_BR_L:
                begin
                    dec.kind = CPC_K_BR;
                    dec.long_disp = 1'b1;
                end
                CPC_CLS_COND:
                begin
                    if (op_word[5:3] == CPC_MODE_DBR)
                        dec.kind = CPC_K_DBR;
                    else if (op_word[5:3] == CPC_MODE_TRAP)
                    begin
                        // Absolute modes stay with set; opmodes 010-100 are trap, rest invalid
                        case (op_word[2:0])
                            CPC_EA_ABS_W: dec.kind = CPC_K_SET;
                            CPC_EA_ABS_L: dec.kind = CPC_K_SET;
                            CPC_TRAP_OP1:
                            begin
                                dec.kind = CPC_K_TRAP;
                                dec.opwords = 2'h1;
                            end
                            CPC_TRAP_OP2:
                            begin
                                dec.kind = CPC_K_TRAP;
                                dec.opwords = 2'h2;
                            end
                            CPC_TRAP_OP0: dec.kind = CPC_K_TRAP;
                            default: dec.kind = CPC_K_BAD;
                        endcase
                    end
                    else
                        dec.kind = CPC_K_SET;
                end
                default: dec.kind = CPC_K_BAD;
            endcase
        end
    end
endmodule // cpc_decode

// ===== hw/cpc_cond_seq.sv
// Purpose: Processor-side sequencer for coprocessor conditional
//          instructions: branch, set byte, decrement-branch, trap.
// Assumes: Coprocessor uses a four-phase req/ack handshake on pins.
// Notes:   Effective address and primitive services are outside.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module cpc_cond_seq
    import cpc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CPC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Coprocessor interface register port
    output logic cp_req,
    output logic cp_wr,
    output logic cp_cir_sel,
    output logic [2:0] cp_id,
    output logic [15:0] cp_wdata,
    input wire logic cp_ack,
    input wire logic [15:0] cp_rdata,
    // Exception and completion pulses
    output logic exc_trap,
    output logic exc_protocol,
    output logic insn_done
);
    // ============================================================
    // Reset release
    logic rst_meta;
    logic rst_n_s;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n_s <= rst_meta;
        end
    end

    // ============================================================
    // Pin synchronisers
    logic [16:0] pin_s;
    logic ack_s;
    logic [15:0] rsp_s;

    cpc_sync #(.W(17)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n_s),
        .d({cp_ack, cp_rdata}),
        .q(pin_s)
    );

    assign ack_s = pin_s[16];
    assign rsp_s = pin_s[15:0];

    // ============================================================
    // Software-visible state
    cpc_state_t state;
    logic [15:0] op_word;
    logic [15:0] sel_word;
    logic [3:0] ext_cnt;
    logic [2:0] ea_cnt;
    logic [31:0] scan_op;
    logic [31:0] disp;
    logic [31:0] counter;
    logic [31:0] next_pc;
    logic [7:0] set_byte;
    logic [15:0] svc_cnt;
    logic [15:0] rsp;
    logic st_done;
    logic st_cond;
    logic st_taken;
    logic st_trap;
    logic st_bad;
    logic st_proto;
    cpc_dec_t dec;

    cpc_decode u_dec (
        .op_word(op_word),
        .dec(dec)
    );

    logic busy;
    logic wr_en;
    logic start_req;
    logic inv;
    logic rsp_null;
    logic evt_end;
    logic evt_null;
    logic evt_viol;
    logic evt_svc;
    logic evt_bad;

    assign busy = (state != CPC_S_IDLE);
    assign wr_en = psel & penable & pready & pwrite;
    assign start_req = wr_en & ~busy & (paddr == CPC_A_CTRL)
        & pwdata[CPC_START_BIT];
    // EA words above five make the set form invalid
    assign inv = (dec.kind == CPC_K_BAD) |
        ((dec.kind == CPC_K_SET) & (ea_cnt > CPC_EA_MAX));
    assign rsp_null = (rsp[13:8] == CPC_RSP_NULL);
    assign evt_end = (state == CPC_S_RREL) & ~ack_s;
    assign evt_null = evt_end & rsp_null;
    assign evt_viol = evt_end & ~rsp_null & ~rsp[CPC_RSP_CA];
    assign evt_svc = evt_end & ~rsp_null & rsp[CPC_RSP_CA];
    assign evt_bad = start_req & inv;

    // ============================================================
    // Address arithmetic
    logic [31:0] ext_b;
    logic [31:0] sel_end;
    logic [31:0] disp_at;
    logic [31:0] disp_sx;
    logic [31:0] target;
    logic [31:0] seq_pc;
    logic [15:0] next_cnt;

    always_comb
    begin
        ext_b = {27'h0, ext_cnt, 1'b0};
        sel_end = scan_op + 32'h4 + ext_b;
        disp_at = sel_end;
        disp_sx = {{16{disp[15]}}, disp[15:0]};
        seq_pc = sel_end;
        case (dec.kind)
            CPC_K_BR:
            begin
                // Pointer on first displacement word
                disp_at = scan_op + 32'h2 + ext_b;
                if (dec.long_disp)
                begin
                    disp_sx = disp;
                    seq_pc = disp_at + 32'h4;
                end
                else
                    seq_pc = disp_at + 32'h2;
            end
            CPC_K_SET:
                seq_pc = sel_end + {28'h0, ea_cnt, 1'b0};
            CPC_K_DBR:
                seq_pc = disp_at + 32'h2;
            CPC_K_TRAP:
                seq_pc = sel_end + {29'h0, dec.opwords, 1'b0};
            default:
                seq_pc = sel_end;
        endcase
        target = disp_at + disp_sx;
        next_cnt = counter[15:0] - 16'h1;
    end

    // ============================================================
    // Handshake sequencer
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            state <= CPC_S_IDLE;
            cp_req <= 1'b0;
            cp_wr <= 1'b0;
            cp_cir_sel <= CPC_CIR_COND;
            cp_id <= 3'h0;
            cp_wdata <= 16'h0;
            rsp <= 16'h0;
        end
        else
        begin
            case (state)
                CPC_S_IDLE:
                    if (start_req)
                    begin
                        if (inv)
                            state <= CPC_S_DONE;
                        else
                        begin
                            cp_req <= 1'b1;
                            cp_wr <= 1'b1;
                            cp_cir_sel <= CPC_CIR_COND;
                            cp_id <= op_word[11:9];
                            if (dec.kind == CPC_K_BR)
                                cp_wdata <= op_word;
                            else
                                cp_wdata <= sel_word;
                            state <= CPC_S_WRC;
                        end
                    end
                CPC_S_WRC:
                    if (ack_s)
                    begin
                        cp_req <= 1'b0;
                        state <= CPC_S_WREL;
                    end
                CPC_S_WREL:
                    if (!ack_s)
                    begin
                        cp_req <= 1'b1;
                        cp_wr <= 1'b0;
                        cp_cir_sel <= CPC_CIR_RESP;
                        state <= CPC_S_RDR;
                    end
                CPC_S_RDR:
                    if (ack_s)
                    begin
                        cp_req <= 1'b0;
                        rsp <= rsp_s;
                        state <= CPC_S_RREL;
                    end
                CPC_S_RREL:
                    if (evt_svc)
                    begin
                        cp_req <= 1'b1;
                        state <= CPC_S_RDR;
                    end
                    else if (evt_end)
                        state <= CPC_S_DONE;
                CPC_S_DONE:
                    state <= CPC_S_IDLE;
                default:
                    state <= CPC_S_IDLE;
            endcase
        end
    end

    // ============================================================
    // Instruction completion
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            next_pc <= 32'h0;
            set_byte <= CPC_BYTE_FALSE;
            st_cond <= 1'b0;
            st_taken <= 1'b0;
            st_trap <= 1'b0;
            exc_trap <= 1'b0;
        end
        else
        begin
            exc_trap <= 1'b0;
            if (start_req)
            begin
                st_taken <= 1'b0;
                st_trap <= 1'b0;
            end
            else if (evt_null)
            begin
                st_cond <= rsp[CPC_RSP_COND];
                next_pc <= seq_pc;
                case (dec.kind)
                    CPC_K_BR:
                        if (rsp[CPC_RSP_COND])
                        begin
                            next_pc <= target;
                            st_taken <= 1'b1;
                        end
                    CPC_K_SET:
                        if (rsp[CPC_RSP_COND])
                            set_byte <= CPC_BYTE_TRUE;
                        else
                            set_byte <= CPC_BYTE_FALSE;
                    CPC_K_DBR:
                        // Fall through when the count wraps to minus one
                        if (!rsp[CPC_RSP_COND] && next_cnt != CPC_CNT_END)
                        begin
                            next_pc <= target;
                            st_taken <= 1'b1;
                        end
                    CPC_K_TRAP:
                        if (rsp[CPC_RSP_COND])
                        begin
                            exc_trap <= 1'b1;
                            st_trap <= 1'b1;
                        end
                    default:
                        st_taken <= 1'b0;
                endcase
            end
        end
    end

    // ============================================================
    // Sticky status, service count and pulses
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            st_done <= 1'b0;
            st_bad <= 1'b0;
            st_proto <= 1'b0;
            svc_cnt <= 16'h0;
            exc_protocol <= 1'b0;
            insn_done <= 1'b0;
        end
        else
        begin
            exc_protocol <= evt_viol;
            insn_done <= evt_null | evt_viol | evt_bad;
            if (start_req)
            begin
                st_done <= 1'b0;
                st_proto <= 1'b0;
                st_bad <= inv;
                svc_cnt <= 16'h0;
            end
            else
            begin
                if (evt_null | evt_viol)
                    st_done <= 1'b1;
                if (evt_viol)
                    st_proto <= 1'b1;
                if (evt_svc)
                    svc_cnt <= svc_cnt + 16'h1;
            end
            if (evt_bad)
                st_done <= 1'b1;
        end
    end

    // ============================================================
    // Configuration registers; locked while an instruction runs
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            op_word <= 16'h0;
            sel_word <= 16'h0;
            ext_cnt <= 4'h0;
            ea_cnt <= 3'h0;
            scan_op <= 32'h0;
            disp <= 32'h0;
        end
        else if (wr_en && !busy)
        begin
            case (paddr)
                CPC_A_OPW: op_word <= pwdata[15:0];
                CPC_A_SELW: sel_word <= pwdata[15:0];
                CPC_A_EXT:
                begin
                    ext_cnt <= pwdata[3:0];
                    ea_cnt <= pwdata[CPC_EA_LSB+2:CPC_EA_LSB];
                end
                CPC_A_SCAN: scan_op <= pwdata;
                CPC_A_DISP: disp <= pwdata;
                default: ext_cnt <= ext_cnt;
            endcase
        end
    end

    // Loop counter; decrement touches low half only, APB write loads all
    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            counter <= 32'h0;
        else if (evt_null && dec.kind == CPC_K_DBR && !rsp[CPC_RSP_COND])
            counter[15:0] <= next_cnt;
        else if (wr_en && !busy && paddr == CPC_A_CNT)
            counter <= pwdata;
    end

    // ============================================================
    // APB slave: one wait-free access phase, registered read data
    logic mapped;

    always_comb
    begin
        case (paddr)
            CPC_A_CTRL, CPC_A_OPW, CPC_A_SELW, CPC_A_EXT, CPC_A_SCAN,
            CPC_A_DISP, CPC_A_CNT, CPC_A_STAT, CPC_A_NPC, CPC_A_BYTE,
            CPC_A_SVC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= 32'h0;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    CPC_A_CTRL: prdata <= {31'h0, busy};
                    CPC_A_OPW: prdata <= {16'h0, op_word};
                    CPC_A_SELW: prdata <= {16'h0, sel_word};
                    CPC_A_EXT: prdata <= {25'h0, ea_cnt, ext_cnt};
                    CPC_A_SCAN: prdata <= scan_op;
                    CPC_A_DISP: prdata <= disp;
                    CPC_A_CNT: prdata <= counter;
                    CPC_A_STAT: prdata <= {20'h0, dec.kind, dec.dreg,
                        st_proto, st_bad, st_trap, st_taken, st_cond,
                        st_done};
                    CPC_A_NPC: prdata <= next_pc;
                    CPC_A_BYTE: prdata <= {24'h0, set_byte};
                    CPC_A_SVC: prdata <= {16'h0, svc_cnt};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule // cpc_cond_seq

// ===== sim/cpc_cond_seq_sva.sv
// Purpose: Port checker for the condition sequencer.
// Assumes: Bound to cpc_cond_seq; one clock domain.
// Notes:   Sync of ack adds two edges to every handshake.
`timescale 1ns/100ps
module cpc_cond_seq_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Coprocessor port
    input wire logic cp_req,
    input wire logic cp_wr,
    input wire logic cp_cir_sel,
    input wire logic [15:0] cp_wdata,
    input wire logic cp_ack,
    // Pulses
    input wire logic exc_trap,
    input wire logic exc_protocol,
    input wire logic insn_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // Assertions
    cond_first_a: assert property ($rose(cp_req) && cp_wr |-> !cp_cir_sel)
        else $error("write not aimed at condition port");
    resp_read_a: assert property (cp_req && !cp_wr |-> cp_cir_sel)
        else $error("read not aimed at response port");
    req_hold_a: assert property (cp_req && !cp_ack && !$past(cp_ack) |=> cp_req)
        else $error("request dropped before ack");
    word_stable_a: assert property (cp_req && $past(cp_req) |->
        $stable(cp_wdata) && $stable(cp_wr))
        else $error("request changed while pending");
    four_phase_a: assert property ($rose(cp_req) |-> !cp_ack && !$past(cp_ack))
        else $error("request raised while ack high");
    ack_drop_a: assert property ($rose(cp_ack) && cp_req |-> ##[1:4] !cp_req)
        else $error("request not released after ack");
    trap_pulse_a: assert property (exc_trap |=> !exc_trap)
        else $error("trap pulse too long");
    proto_done_a: assert property (exc_protocol |-> insn_done && !exc_trap)
        else $error("violation without completion");
    done_idle_a: assert property (insn_done |-> !cp_req)
        else $error("completion while bus busy");
    cover property (exc_trap);
    cover property (exc_protocol);
    cover property ($rose(cp_req) && !cp_wr);
endmodule // cpc_cond_seq_sva

bind cpc_cond_seq cpc_cond_seq_sva u_sva (.*);

// ===== sim/cpc_copro_model.sv
// Purpose: Behavioural coprocessor behind the interface registers.
// Assumes: Four-phase req/ack; bench sets delay and answers.
// Notes:   Data line shows inverted junk once ack is gone.
`timescale 1ns/100ps
module cpc_copro_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Port from sequencer
    input wire logic cp_req,
    input wire logic cp_wr,
    input wire logic [15:0] cp_wdata,
    output logic cp_ack,
    output logic [15:0] cp_rdata,
    // Bench control and view
    input wire logic [1:0] dly,
    input wire logic [1:0] svc,
    input wire logic cond,
    input wire logic bad,
    output logic [15:0] last
);
    logic [1:0] wt;
    logic [2:0] n;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cp_ack <= 1'b0;
            cp_rdata <= 16'h0;
            last <= 16'h0;
            wt <= 2'h0;
            n <= 3'h0;
        end
        else if (cp_req && !cp_ack)
        begin
            wt <= wt + 2'h1;
            if (wt == dly)
            begin
                wt <= 2'h0;
                cp_ack <= 1'b1;
                if (cp_wr)
                begin
                    last <= cp_wdata;
                    n <= 3'h0;
                end
                else
                begin
                    // Services first with come-again; then null, or non-null without come-again when told to misbehave
                    cp_rdata <= (n < svc) ? 16'h8100 :
                        bad ? 16'h0100 : {15'h0, cond};
                    n <= n + 3'h1;
                end
            end
        end
        else if (!cp_req && cp_ack)
        begin
            cp_ack <= 1'b0;
            cp_rdata <= ~cp_rdata;
        end
    end
endmodule // cpc_copro_model

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the condition sequencer.
// Assumes: Random mix from a fixed-seed shift register.
// Notes:   Outcome read back through the status registers.
`timescale 1ns/100ps
module tb_top
    import cpc_pkg::*;
;
    logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cond = 1'b0, bad = 1'b0, perr, inv, tr;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, rnd = 32'h3767, scan, disp, cnt, st, r;
    logic [31:0] prdata;
    logic pready, pslverr, cp_req, cp_wr, cp_cir_sel, cp_ack;
    logic exc_trap, exc_protocol, insn_done;
    logic [2:0] cp_id, ea;
    logic [15:0] cp_wdata, cp_rdata, last, selw, op;
    logic [1:0] dly = 2'h0, svc = 2'h0;
    logic [3:0] ext;
    int fail_count = 0, n_compared = 0, i, k;
    logic [15:0] tbl [8] = '{16'hf080, 16'hf0c0, 16'hf050, 16'hf048,
        16'hf07a, 16'hf07b, 16'hf07c, 16'hf07d};

    always #5 sys_clk = ~sys_clk;

    cpc_cond_seq u_cpc_cond_seq (.*);
    cpc_copro_model u_cpc_copro_model (.*);

    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] exp_npc(input logic [15:0] o);
        logic [31:0] sp, dw;
        sp = scan + 32'h4 + 32'(ext) * 2;
        dw = {{16{disp[15]}}, disp[15:0]};
        if (o[8:7] == 2'b01)
        begin
            sp = sp - 32'h2;
            if (cond)
                return sp + (o[6] ? disp : dw);
            return sp + (o[6] ? 32'h4 : 32'h2);
        end
        if (o[5:3] == 3'h1)
            return (cond || cnt[15:0] == 16'h0) ? sp + 32'h2 : sp + dw;
        if (o[5:3] == 3'h7)
            return sp + (o[2:0] == 3'h4 ? 32'h0 : 32'(o[2:0] - 3'h1) * 2);
        return sp + 32'(ea) * 2;
    endfunction

    task automatic print_verdict;
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic hang;
        fail_count++;
        $display("BAD %0t timeout", $time);
        print_verdict();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int t;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge sys_clk);
            t++;
        end
        while (pready !== 1'b1 && t < 20);
        if (t >= 20)
            hang();
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ==========================================
    // One instruction
    task automatic run(input int j);
        repeat (16) rnd = lfsr(rnd);
        op = tbl[j % 8] | {4'h0, rnd[11:9], 9'h0};
        if (op[8:7] == 2'b01)
            op[5:0] = rnd[5:0];
        else if (op[5:3] != 3'h7)
            op[2:0] = rnd[2:0];
        inv = op[8:0] == 9'h07d;
        selw = {10'h0, rnd[17:12]};
        ext = rnd[21:18];
        ea = rnd[24:22] % 3'h6;
        dly <= rnd[26:25];
        svc <= rnd[28:27];
        cond <= rnd[0];
        bad <= j == 13;
        scan = lfsr(rnd) & 32'hfffffffe;
        disp = lfsr(scan);
        cnt = j < 8 ? 32'h0 : rnd;
        apb(1'b1, CPC_A_OPW, {16'h0, op}, r);
        apb(1'b1, CPC_A_SELW, {16'h0, selw}, r);
        apb(1'b1, CPC_A_EXT, {25'h0, ea, ext}, r);
        apb(1'b1, CPC_A_SCAN, scan, r);
        apb(1'b1, CPC_A_DISP, disp, r);
        apb(1'b1, CPC_A_CNT, cnt, r);
        apb(1'b1, CPC_A_CTRL, 32'h1, r);
        k = 0;
        do
        begin
            apb(1'b0, CPC_A_CTRL, 32'h0, r);
            k++;
        end
        while (r[0] !== 1'b0 && k < 200);
        if (k >= 200)
            hang();
        tr = !inv && !bad && cond && op[8:3] == 6'h0f;
        apb(1'b0, CPC_A_STAT, 32'h0, st);
        chk(32'({st[5:3], st[0]}), 32'({bad, inv, tr, 1'b1}));
        if (inv)
            return;
        chk(32'({cp_id, last}),
            32'({op[11:9], op[8:7] == 2'b01 ? op : selw}));
        if (bad || tr)
            return;
        apb(1'b0, CPC_A_NPC, 32'h0, r);
        chk(r, exp_npc(op));
        apb(1'b0, CPC_A_SVC, 32'h0, r);
        chk(r, 32'(svc));
        if (op[8:3] == 6'h0a)
        begin
            apb(1'b0, CPC_A_BYTE, 32'h0, r);
            chk(r, cond ? 32'hff : 32'h0);
        end
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, CPC_A_STAT, 32'h0, r);
        chk(r, 32'h800);
        apb(1'b0, 8'hfc, 32'h0, r);
        chk({perr, r[30:0]}, 32'h80000000);
        for (i = 0; i < 32; i++)
            run(i);
        print_verdict();
    end
endmodule // tb_top
